// ### rtl/acr_pkg.sv
// package for the converter result, channel and pin mode registers
package acr_pkg;

  localparam logic [19:0] ACR_OFS_ANALOG_SEL  = 20'hF0060;
  localparam logic [19:0] ACR_OFS_RESULT_LOW  = 20'hFFF1E;
  localparam logic [19:0] ACR_OFS_RESULT_HIGH = 20'hFFF1F;
  localparam logic [19:0] ACR_OFS_DIRECTION   = 20'hFFF20;
  localparam logic [19:0] ACR_OFS_CHANNEL     = 20'hFFF31;

  localparam logic [7:0] ACR_RST_RESULT     = 8'h00;
  localparam logic [7:0] ACR_RST_CHANNEL    = 8'h00;
  localparam logic [7:0] ACR_RST_ANALOG_SEL = 8'hFF;
  localparam logic [7:0] ACR_RST_DIRECTION  = 8'hFF;

  // writable field masks; the rest read as fixed values
  localparam logic [7:0] ACR_MASK_ANALOG_SEL = 8'h1E;
  localparam logic [7:0] ACR_MASK_DIRECTION  = 8'h1F;
  localparam logic [7:0] ACR_MASK_CHANNEL    = 8'h03;
  localparam logic [7:0] ACR_FIX_ANALOG_SEL  = 8'hE1;
  localparam logic [7:0] ACR_FIX_DIRECTION   = 8'hE0;

  localparam int ACR_RES_BITS = 10;
  localparam int ACR_NUM_ANI  = 4;

  // cpu access bundle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  bmask;
  } acr_cpu_req_t;

  // converter core side
  typedef struct packed {
    logic       done;
    logic [9:0] successive_approx_register;
  } acr_core_t;

endpackage

// ### rtl/acr_pin_mux.sv
// per-pin function decode for the four shared analog/digital pins
`timescale 1ns/100ps
module acr_pin_mux #(
  parameter int NUM_ANI = 4
) (
  input  wire logic [NUM_ANI-1:0] analog_sel,  // analog mode per pin
  input  wire logic [NUM_ANI-1:0] dir_in,      // 1 input mode per pin
  input  wire logic [1:0]         channel,     // selected analog input
  input  wire logic [NUM_ANI-1:0] pin_level,   // raw pin levels
  output logic      [NUM_ANI-1:0] read_level,  // port read value
  output logic      [NUM_ANI-1:0] ani_connect, // pin routed to converter
  output logic      [NUM_ANI-1:0] ani_idle,    // analog, not converted
  output logic      [NUM_ANI-1:0] mode_bad     // analog with output mode
);
  import acr_pkg::*;

  for (genvar i = 0; i < NUM_ANI; i++)
  begin : g_pin
    always_comb
    begin
      read_level[i]  = pin_level[i] & ~analog_sel[i];
      ani_connect[i] = analog_sel[i] & dir_in[i] & (channel == 2'(i));
      ani_idle[i]    = analog_sel[i] & dir_in[i] & (channel != 2'(i));
      mode_bad[i]    = analog_sel[i] & ~dir_in[i];
    end
  end

endmodule

// ### rtl/acr_regs.sv
// result, channel select and port mode registers of the converter
`timescale 1ns/100ps
module acr_regs #(
  parameter int NUM_ANI = acr_pkg::ACR_NUM_ANI
) (
  input  wire logic                 mclk,          // 125 MHz clock
  input  wire logic                 rst_b,         // sync reset, active low
  input  wire logic                 clk_en,        // freezes state when low
  input  wire acr_pkg::acr_cpu_req_t cpu,          // cpu byte access
  output logic      [7:0]           cpu_rdata,     // read data, registered
  input  wire acr_pkg::acr_core_t   core,          // end pulse and sar value
  input  wire logic                 resolution_select, // 1 selects 8-bit
  input  wire logic                 conversion_start_bit, // conversion running
  output logic                      conv_end_clear, // clears start bit, pulse
  output logic                      conversion_done_irq, // end request, pulse
  output logic      [1:0]           ani_channel,   // to analog multiplexer
  input  wire logic [NUM_ANI-1:0]   pin_level,     // shared pin levels
  output logic      [NUM_ANI-1:0]   pin_oe,        // pin output buffer enable
  output logic      [NUM_ANI-1:0]   ani_connect,   // pin sampled by converter
  output logic      [NUM_ANI-1:0]   ani_idle,      // analog, not converted
  output logic      [NUM_ANI-1:0]   mode_bad,      // prohibited combination
  output logic      [NUM_ANI-1:0]   port_read      // digital read value
);
  import acr_pkg::*;

  logic [7:0] result_high, next_result_high;
  logic [7:0] result_low, next_result_low;
  logic [7:0] channel, next_channel;
  logic [7:0] analog_sel, next_analog_sel;
  logic [7:0] direction, next_direction;
  logic [7:0] rdata, next_rdata;
  logic       end_q, next_end_q;

  function automatic logic [7:0] merge(input logic [7:0] old, input acr_cpu_req_t r,
                                       input logic [7:0] mask, input logic [7:0] fix);
    merge = (((old & ~r.bmask) | (r.wdata & r.bmask)) & mask) | fix;
  endfunction

  function automatic logic hit(input acr_cpu_req_t r, input logic [19:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_result_high = result_high;
    next_result_low  = result_low;
    next_channel     = channel;
    next_analog_sel  = analog_sel;
    next_direction   = direction;
    next_end_q       = core.done;
    if (core.done)
    begin
      next_result_high = core.successive_approx_register[9:2];
      // 8-bit mode forces the two extra bits low once stored
      next_result_low  = resolution_select ? 8'h00
                                           : {core.successive_approx_register[1:0], 6'h00};
    end
    // result bytes have no write path
    if (hit(cpu, ACR_OFS_CHANNEL))
      next_channel = merge(channel, cpu, ACR_MASK_CHANNEL, 8'h00);
    if (hit(cpu, ACR_OFS_ANALOG_SEL))
      next_analog_sel = merge(analog_sel, cpu, ACR_MASK_ANALOG_SEL,
                              ACR_FIX_ANALOG_SEL);
    if (hit(cpu, ACR_OFS_DIRECTION))
      next_direction = merge(direction, cpu, ACR_MASK_DIRECTION,
                             ACR_FIX_DIRECTION);
    next_rdata = 8'h00;
    if (cpu.rd)
    begin
      unique case (cpu.addr)
        ACR_OFS_RESULT_HIGH: next_rdata = result_high;
        ACR_OFS_RESULT_LOW:  next_rdata = result_low & 8'hC0;
        ACR_OFS_CHANNEL:     next_rdata = channel;
        ACR_OFS_ANALOG_SEL:  next_rdata = analog_sel;
        ACR_OFS_DIRECTION:   next_rdata = direction;
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      result_high <= ACR_RST_RESULT;
      result_low  <= ACR_RST_RESULT;
      channel     <= ACR_RST_CHANNEL;
      analog_sel  <= ACR_RST_ANALOG_SEL;
      direction   <= ACR_RST_DIRECTION;
      rdata       <= 8'h00;
      end_q       <= 1'b0;
    end
    else if (clk_en)
    begin
      result_high <= next_result_high;
      result_low  <= next_result_low;
      channel     <= next_channel;
      analog_sel  <= next_analog_sel;
      direction   <= next_direction;
      rdata       <= next_rdata;
      end_q       <= next_end_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cpu_rdata           = rdata;
  assign conv_end_clear      = end_q;
  assign conversion_done_irq = end_q;
  assign ani_channel         = channel[1:0];
  assign pin_oe              = ~direction[NUM_ANI:1];

  acr_pin_mux #(
    .NUM_ANI (NUM_ANI)
  ) u_pin_mux (
    .analog_sel  (analog_sel[NUM_ANI:1]),
    .dir_in      (direction[NUM_ANI:1]),
    .channel     (channel[1:0]),
    .pin_level   (pin_level),
    .read_level  (port_read),
    .ani_connect (ani_connect),
    .ani_idle    (ani_idle),
    .mode_bad    (mode_bad)
  );

  ////////////////////////////////////////////////////////////////////////////
  // result bytes
  a_result_load: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && core.done |=> result_high == $past(core.successive_approx_register[9:2]))
    else $error("high byte not loaded at conversion end");
  a_low_layout: assert property (@(posedge mclk) disable iff (!rst_b)
    result_low[5:0] == 6'h00)
    else $error("low result bits nonzero");
  a_eight_bit_low: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && core.done && resolution_select |=> result_low == 8'h00)
    else $error("8-bit mode low byte not zero");
  // a mid-run reset also clears the bytes, so the hold starts only out of reset
  a_result_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    rst_b && !core.done |=> $stable(result_high) && $stable(result_low))
    else $error("result changed without conversion end");
  a_reset_vals: assert property (@(posedge mclk)
    !rst_b |=> result_high == 8'h00 && channel == 8'h00 && direction == 8'hFF)
    else $error("reset values wrong");
  a_end_irq: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && core.done |=> conversion_done_irq && conv_end_clear)
    else $error("end request missing");
  a_end_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && !core.done |=> !conversion_done_irq && !conv_end_clear)
    else $error("end request longer than one cycle");

  // channel select
  a_chan_mux: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && hit(cpu, ACR_OFS_CHANNEL) && cpu.bmask == 8'hFF
    |=> ani_channel == $past(cpu.wdata[1:0]))
    else $error("channel output mismatch");
  a_chan_upper: assert property (@(posedge mclk) disable iff (!rst_b)
    channel[7:2] == 6'h00)
    else $error("channel upper bits nonzero");
  a_chan_steady: assert property (@(posedge mclk) disable iff (!rst_b)
    rst_b && conversion_start_bit && !hit(cpu, ACR_OFS_CHANNEL) |=> $stable(ani_channel))
    else $error("channel moved during conversion");

  // port mode registers and pin functions
  a_fixed_ones: assert property (@(posedge mclk) disable iff (!rst_b)
    analog_sel[7:5] == 3'h7 && analog_sel[0] && direction[7:5] == 3'h7)
    else $error("fixed bits not one");
  a_analog_write: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && hit(cpu, ACR_OFS_ANALOG_SEL) && cpu.bmask == 8'hFF
    |=> analog_sel == (($past(cpu.wdata) & ACR_MASK_ANALOG_SEL) | ACR_FIX_ANALOG_SEL))
    else $error("analog select write not applied");
  a_dir_write: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && hit(cpu, ACR_OFS_DIRECTION) && cpu.bmask == 8'hFF
    |=> direction == (($past(cpu.wdata) & ACR_MASK_DIRECTION) | ACR_FIX_DIRECTION))
    else $error("direction write not applied");
  a_output_no_ani: assert property (@(posedge mclk) disable iff (!rst_b)
    (pin_oe & ani_connect) == '0)
    else $error("output-mode pin routed to converter");
  a_analog_read: assert property (@(posedge mclk) disable iff (!rst_b)
    (port_read & analog_sel[NUM_ANI:1]) == '0)
    else $error("analog pin read nonzero");
  a_digital_read: assert property (@(posedge mclk) disable iff (!rst_b)
    ((port_read ^ pin_level) & ~analog_sel[NUM_ANI:1]) == '0)
    else $error("digital pin read differs from pin level");
  a_idle_excl: assert property (@(posedge mclk) disable iff (!rst_b)
    (ani_connect & ani_idle) == '0)
    else $error("pin both converted and idle");
  a_one_connect: assert property (@(posedge mclk) disable iff (!rst_b)
    $onehot0(ani_connect))
    else $error("more than one pin routed to converter");
  a_bad_mode: assert property (@(posedge mclk) disable iff (!rst_b)
    (mode_bad & (ani_connect | ani_idle)) == '0)
    else $error("prohibited pin mode used as analog input");

  // read path and clock enable
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    clk_en && !cpu.rd |=> cpu_rdata == 8'h00)
    else $error("read data not zero between reads");
  a_freeze: assert property (@(posedge mclk) disable iff (!rst_b)
    rst_b && !clk_en |=> $stable({channel, direction, analog_sel, result_high, result_low}))
    else $error("state changed while clock enable low");

  c_conv_end: cover property (@(posedge mclk) disable iff (!rst_b) core.done && clk_en);
  c_eight_bit: cover property (@(posedge mclk) disable iff (!rst_b)
    core.done && resolution_select && clk_en);
  c_chan_three: cover property (@(posedge mclk) disable iff (!rst_b) channel[1:0] == 2'h3);
  c_ani_sel: cover property (@(posedge mclk) disable iff (!rst_b) |ani_connect);
  c_frozen_write: cover property (@(posedge mclk) disable iff (!rst_b) !clk_en && cpu.wr);

endmodule

// ### dv/acr_core_model.sv
// stand-in for the converter core: one conversion per start pulse
`timescale 1ns/100ps
module acr_core_model #(
  parameter int CONV_CYC = 5
) (
  input  wire logic         mclk,    // peripheral clock
  input  wire logic         start,   // start request, one cycle
  input  wire logic [9:0]   value,   // result the core will settle on
  input  wire logic         clr,     // start-bit clear from the registers
  output acr_pkg::acr_core_t core,   // end pulse and sar
  output logic              running  // conversion start bit
);
  import acr_pkg::*;
  int cnt = 0;
  initial core = '0;
  initial running = 1'b0;
  //////////////////////////////////////////////////
  // sar is only meaningful with done, so it toggles otherwise
  always @(posedge mclk)
  begin
    core <= '{done: (cnt == 1), successive_approx_register: (cnt == 1) ? value : ~core.successive_approx_register};
    if (start)
    begin
      running <= 1'b1;
      cnt <= CONV_CYC;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
    if (clr)
      running <= 1'b0;
  end
endmodule

// ### dv/acr_regs_tb.sv
// self-checking bench for the result, channel and pin mode registers
`timescale 1ns/100ps
module acr_regs_tb;
  import acr_pkg::*;
  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  acr_cpu_req_t cpu = '0;
  acr_core_t    core;
  logic [7:0]   cpu_rdata;
  logic         res8 = 1'b0, start = 1'b0, en = 1'b1, running, clr, irq;
  logic [9:0]   value = '0;
  logic [1:0]   chan;
  logic [3:0]   pins = 4'hF, oe, conn, idle, bad, prd;
  int           num_errors = 0, total_checks = 0, cycles = 0;
  always #4 mclk = ~mclk;
  acr_regs i_dut (.mclk(mclk), .rst_b(rst_b), .clk_en(en), .cpu(cpu), .cpu_rdata(cpu_rdata),
    .core(core), .resolution_select(res8), .conversion_start_bit(running),
    .conv_end_clear(clr), .conversion_done_irq(irq), .ani_channel(chan), .pin_level(pins),
    .pin_oe(oe), .ani_connect(conn), .ani_idle(idle), .mode_bad(bad), .port_read(prd));
  acr_core_model i_core (.mclk(mclk), .start(start), .value(value), .clr(clr), .core(core),
    .running(running));
  //////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [7:0] m = 8'hFF);
    @(posedge mclk);
    cpu <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d, bmask: m};
    @(posedge mclk);
    cpu <= '0;
    #1;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    cpu <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00, bmask: 8'h00};
    @(posedge mclk);
    cpu <= '0;
    #1 chk(what, exp, cpu_rdata);
  endtask
  task automatic conv(input logic [9:0] v, input logic [7:0] hi, input logic [7:0] lo);
    @(posedge mclk);
    value <= v;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    for (int n = 0; n < 30 && irq !== 1'b1; n++) @(posedge mclk) #1;
    chk("end request", 8'h01, {7'h00, irq});
    chk("start clear", 8'h01, {7'h00, clr});
    @(posedge mclk) #1 chk("end pulse width", 8'h00, {7'h00, irq});
    rd(ACR_OFS_RESULT_HIGH, hi, "result high");
    rd(ACR_OFS_RESULT_LOW, lo, "result low");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////
  // cut a hang short; the sequence needs well under 1000 cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      $display("MISMATCH run length expected under 3000 seen 3000");
      test_done();
    end
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    rd(ACR_OFS_RESULT_HIGH, 8'h00, "reset high");
    rd(ACR_OFS_RESULT_LOW, 8'h00, "reset low");
    rd(ACR_OFS_CHANNEL, 8'h00, "reset channel");
    rd(ACR_OFS_ANALOG_SEL, 8'hFF, "reset analog select");
    rd(ACR_OFS_DIRECTION, 8'hFF, "reset direction");
    rd(20'h00001, 8'h00, "unmapped");
    $display("test reset finished");
    conv(10'h2B5, 8'hAD, 8'h40);
    wr(ACR_OFS_RESULT_HIGH, 8'h12);
    rd(ACR_OFS_RESULT_HIGH, 8'hAD, "high after write");
    conv(10'h3FF, 8'hFF, 8'hC0);
    @(posedge mclk) res8 <= 1'b1;
    conv(10'h3FF, 8'hFF, 8'h00);
    @(posedge mclk) res8 <= 1'b0;
    $display("test conversion finished");
    for (int c = 0; c < 4; c++)
    begin
      wr(ACR_OFS_CHANNEL, 8'(c));
      chk("mux channel", 8'(c), {6'h00, chan});
    end
    wr(ACR_OFS_CHANNEL, 8'h00, 8'h01);
    rd(ACR_OFS_CHANNEL, 8'h02, "channel bit write");
    $display("test channel finished");
    wr(ACR_OFS_CHANNEL, 8'h01);
    wr(ACR_OFS_ANALOG_SEL, 8'h06);
    wr(ACR_OFS_DIRECTION, 8'hFD);
    rd(ACR_OFS_ANALOG_SEL, 8'hE7, "analog select");
    rd(ACR_OFS_DIRECTION, 8'hFD, "direction");
    chk("pin oe", 8'h01, {4'h0, oe});
    chk("port read", 8'h0C, {4'h0, prd});
    chk("connect", 8'h02, {4'h0, conn});
    chk("bad mode", 8'h01, {4'h0, bad});
    wr(ACR_OFS_CHANNEL, 8'h00);
    chk("output pin connect", 8'h00, {4'h0, conn});
    wr(ACR_OFS_DIRECTION, 8'hFF);
    chk("idle", 8'h02, {4'h0, idle});
    chk("connect input pin", 8'h01, {4'h0, conn});
    $display("test pins finished");
    @(posedge mclk) en <= 1'b0;
    wr(ACR_OFS_CHANNEL, 8'h03);
    chk("frozen channel", 8'h00, {6'h00, chan});
    @(posedge mclk) en <= 1'b1;
    conv(10'h155, 8'h55, 8'h40);
    @(posedge mclk) rst_b <= 1'b0;
    @(posedge mclk) rst_b <= 1'b1;
    rd(ACR_OFS_RESULT_HIGH, 8'h00, "reset again high");
    rd(ACR_OFS_RESULT_LOW, 8'h00, "reset again low");
    rd(ACR_OFS_ANALOG_SEL, 8'hFF, "reset again analog select");
    $display("test freeze and reset finished");
    test_done();
  end
endmodule
